/* File: core/omdiag_bank.sv */
// Notes on behaviour
// - Temperature is signed, 1/256 degree steps.
// - Supply voltage unsigned, 100 microvolt steps.
// - Laser bias unsigned, 2 microampere steps.
// - Transmit power unsigned, 0.1 microwatt steps.
// - Receive power unsigned, 0.1 microwatt steps.
// - Calibration bytes read fixed factory values.
// - Byte 95 checksum reads back unchanged.
// - Byte 127 write acknowledged, does nothing.
// - Bytes 128 to 247 store host writes.
// - Status bit 7 shows transmit-disable pin.
// - Status bit 6 is host soft disable.
// - Transmitter off when soft or pin disable.
// - Bit 4 shows rate pin; full bandwidth except while in reset.
// - Status bit 2 mirrors transmit fault pin.
// - Status bit 1 mirrors signal loss pin.
// - Bit 0 reads zero once measurements valid.
// - Byte 112 holds main alarm flags.
// - Byte 113 holds receive power alarms.
// - Byte 116 holds main warning flags.
// - Byte 117 holds receive power warnings.
// - Measurements in byte pairs, MSB first, from 96.
`timescale 1ns/1ps
`include "omdiag_params.svh"
module omdiag_bank import omdiag_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int SYNC_STAGES = 3
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic factory_we,
  input wire logic [6:0] factory_idx,
  input wire logic [7:0] factory_byte,
  input wire logic [15:0] temp_meas,
  input wire logic [15:0] vcc_meas,
  input wire logic [15:0] bias_meas,
  input wire logic [15:0] txpwr_meas,
  input wire logic [15:0] rxpwr_meas,
  input wire logic meas_valid,
  input wire logic tx_fault_in,
  input wire logic signal_loss_in,
  input wire logic tx_disable_pin,
  input wire logic rate_select_pin,
  output logic tx_fault_pin,
  output logic signal_loss_pin_level,
  output logic transmitter_off,
  output logic full_bandwidth
);
  localparam int NCH = 5;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] fact_mem [0:`OMD_FACT_DEPTH-1];
  logic [7:0] user_mem [0:`OMD_USER_DEPTH-1];
  logic [15:0] meas_reg [0:NCH-1];
  logic [15:0] meas_in [0:NCH-1];
  logic ready_reg, ready_next;

  // Factory image is nonvolatile: not cleared by reset
  always_ff @(posedge ref_clk) begin
    if (factory_we && (factory_idx <= 7'(`OMD_IDX_CHECKSUM))) begin
      fact_mem[factory_idx] <= factory_byte;
    end
  end

  // ****************************************
  // Measurement snapshot
  // ****************************************
  always_comb begin
    meas_in[OMD_CH_TEMP] = temp_meas;
    meas_in[OMD_CH_VCC] = vcc_meas;
    meas_in[OMD_CH_BIAS] = bias_meas;
    meas_in[OMD_CH_TXPWR] = txpwr_meas;
    meas_in[OMD_CH_RXPWR] = rxpwr_meas;
    ready_next = ready_reg | meas_valid;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_reg <= 1'b0;
      for (int k = 0; k < NCH; k++) begin
        meas_reg[k] <= 16'h0000;
      end
    end else begin
      ready_reg <= ready_next;
      for (int k = 0; k < NCH; k++) begin
        if (meas_valid) begin
          meas_reg[k] <= meas_in[k];
        end
      end
    end
  end

  // ****************************************
  // Threshold comparison
  // ****************************************
  logic [NCH-1:0] alm_hi, alm_lo, wrn_hi, wrn_lo;
  logic [7:0] alm_main_reg, alm_main_next, alm_rx_reg, alm_rx_next;
  logic [7:0] wrn_main_reg, wrn_main_next, wrn_rx_reg, wrn_rx_next;

  for (genvar k = 0; k < NCH; k++) begin : g_cmp
    localparam int B = k * `OMD_THR_STRIDE;
    omdiag_flag_cmp #(.IS_SIGNED(k == OMD_CH_TEMP)) u_alm (
      .value(meas_reg[k]),
      .hi_thr({fact_mem[B+`OMD_THR_HI_ALM], fact_mem[B+`OMD_THR_HI_ALM+1]}),
      .lo_thr({fact_mem[B+`OMD_THR_LO_ALM], fact_mem[B+`OMD_THR_LO_ALM+1]}),
      .above_hi(alm_hi[k]),
      .below_lo(alm_lo[k])
    );
    omdiag_flag_cmp #(.IS_SIGNED(k == OMD_CH_TEMP)) u_wrn (
      .value(meas_reg[k]),
      .hi_thr({fact_mem[B+`OMD_THR_HI_WRN], fact_mem[B+`OMD_THR_HI_WRN+1]}),
      .lo_thr({fact_mem[B+`OMD_THR_LO_WRN], fact_mem[B+`OMD_THR_LO_WRN+1]}),
      .above_hi(wrn_hi[k]),
      .below_lo(wrn_lo[k])
    );
  end

  always_comb begin
    alm_main_next = 8'h00;
    wrn_main_next = 8'h00;
    alm_rx_next = 8'h00;
    wrn_rx_next = 8'h00;
    if (ready_reg) begin
      alm_main_next = {alm_hi[0], alm_lo[0], alm_hi[1], alm_lo[1],
                       alm_hi[2], alm_lo[2], alm_hi[3], alm_lo[3]};
      wrn_main_next = {wrn_hi[0], wrn_lo[0], wrn_hi[1], wrn_lo[1],
                       wrn_hi[2], wrn_lo[2], wrn_hi[3], wrn_lo[3]};
      alm_rx_next = {alm_hi[4], alm_lo[4], 6'h00};
      wrn_rx_next = {wrn_hi[4], wrn_lo[4], 6'h00};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alm_main_reg <= 8'h00;
      alm_rx_reg <= 8'h00;
      wrn_main_reg <= 8'h00;
      wrn_rx_reg <= 8'h00;
    end else begin
      alm_main_reg <= alm_main_next;
      alm_rx_reg <= alm_rx_next;
      wrn_main_reg <= wrn_main_next;
      wrn_rx_reg <= wrn_rx_next;
    end
  end

  // ****************************************
  // Pin synchronisers and pin mirrors
  // ****************************************
  logic [1:0] s1_reg, s2_reg, s3_reg, pin_stable_reg, pin_stable_next;
  logic soft_dis_reg, soft_dis_next;
  logic tx_off_reg, fault_reg, los_reg, full_bw_reg;

  // A pin change counts once the second and third stages agree
  always_comb begin
    pin_stable_next = (s2_reg & s3_reg) | (pin_stable_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
      pin_stable_reg <= 2'h0;
      tx_off_reg <= 1'b1;
      fault_reg <= 1'b0;
      los_reg <= 1'b0;
      full_bw_reg <= 1'b0;
    end else begin
      s1_reg <= {rate_select_pin, tx_disable_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_stable_reg <= pin_stable_next;
      tx_off_reg <= soft_dis_reg | pin_stable_reg[0];
      fault_reg <= tx_fault_in;
      los_reg <= signal_loss_in;
      full_bw_reg <= 1'b1;
    end
  end

  assign tx_fault_pin = fault_reg;
  assign signal_loss_pin_level = los_reg;
  assign transmitter_off = tx_off_reg;
  assign full_bandwidth = full_bw_reg;

  // ****************************************
  // Write channels
  // ****************************************
  omd_wr_state_t wr_state_reg, wr_state_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next;
  logic [1:0] bresp_reg, bresp_next;
  logic user_we;
  logic [`OMD_IDX_W-1:0] wr_idx;
  logic wr_mapped, do_write;
  logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bresp_next = bresp_reg;
    wr_state_next = wr_state_reg;
    soft_dis_next = soft_dis_reg;
    user_we = 1'b0;
    wr_idx = aw_addr_reg[`OMD_IDX_W+1:2];
    wr_mapped = (aw_addr_reg[ADDR_W-1:`OMD_IDX_W+2] == '0);
    do_write = 1'b0;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      w_byte_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    case (wr_state_reg)
      OMD_WR_COLLECT: begin
        if (aw_held_reg && w_held_reg) begin
          do_write = 1'b1;
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          wr_state_next = OMD_WR_RESPOND;
          bresp_next = wr_mapped ? `OMD_RESP_OKAY : `OMD_RESP_SLVERR;
          if (wr_mapped && w_lane_reg) begin
            if (wr_idx == `OMD_IDX_STATUS) begin
              soft_dis_next = w_byte_reg[`OMD_ST_SOFT_DIS];
            end
            if (wr_idx >= `OMD_IDX_USER_FIRST && wr_idx <= `OMD_IDX_USER_LAST) begin
              user_we = 1'b1;
            end
          end
        end
      end
      OMD_WR_RESPOND: begin
        if (s_axi_bready) begin
          wr_state_next = OMD_WR_COLLECT;
        end
      end
      default: wr_state_next = OMD_WR_COLLECT;
    endcase
    awready_next = !aw_held_next;
    wready_next = !w_held_next;
    bvalid_next = (wr_state_next == OMD_WR_RESPOND);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_state_reg <= OMD_WR_COLLECT;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bresp_reg <= `OMD_RESP_OKAY;
      soft_dis_reg <= 1'b0;
    end else begin
      wr_state_reg <= wr_state_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      bresp_reg <= bresp_next;
      soft_dis_reg <= soft_dis_next;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `OMD_USER_DEPTH; i++) begin
        user_mem[i] <= 8'h00;
      end
    end else if (user_we) begin
      user_mem[7'(wr_idx - `OMD_IDX_USER_FIRST)] <= w_byte_reg;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ****************************************
  // Read channel
  // ****************************************
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [7:0] rbyte_reg, rbyte_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] status_byte, page_byte;
  logic [`OMD_IDX_W-1:0] rd_idx;
  logic [15:0] rd_word;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`OMD_ST_TXDIS_PIN] = pin_stable_reg[0];
    status_byte[`OMD_ST_SOFT_DIS] = soft_dis_reg;
    status_byte[`OMD_ST_RATE_PIN] = pin_stable_reg[1];
    status_byte[`OMD_ST_FAULT] = fault_reg;
    status_byte[`OMD_ST_LOS] = los_reg;
    status_byte[`OMD_ST_READY_N] = !ready_reg;
    rd_idx = s_axi_araddr[`OMD_IDX_W+1:2];
    rd_word = meas_reg[3'((rd_idx - `OMD_IDX_MEAS_FIRST) >> 1)];
    page_byte = 8'h00;
    if (rd_idx <= `OMD_IDX_CHECKSUM) begin
      page_byte = fact_mem[7'(rd_idx)];
    end else if (rd_idx <= `OMD_IDX_MEAS_LAST) begin
      page_byte = rd_idx[0] ? rd_word[7:0] : rd_word[15:8];
    end else if (rd_idx >= `OMD_IDX_USER_FIRST && rd_idx <= `OMD_IDX_USER_LAST) begin
      page_byte = user_mem[7'(rd_idx - `OMD_IDX_USER_FIRST)];
    end else begin
      case (rd_idx)
        `OMD_IDX_STATUS: page_byte = status_byte;
        `OMD_IDX_ALM_MAIN: page_byte = alm_main_reg;
        `OMD_IDX_ALM_RX: page_byte = alm_rx_reg;
        `OMD_IDX_WRN_MAIN: page_byte = wrn_main_reg;
        `OMD_IDX_WRN_RX: page_byte = wrn_rx_reg;
        default: page_byte = 8'h00;
      endcase
    end
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rbyte_next = rbyte_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      if (s_axi_araddr[ADDR_W-1:`OMD_IDX_W+2] == '0) begin
        rbyte_next = page_byte;
        rresp_next = `OMD_RESP_OKAY;
      end else begin
        rbyte_next = 8'h00;
        rresp_next = `OMD_RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      arready_next = 1'b1;
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rbyte_reg <= 8'h00;
      rresp_reg <= `OMD_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rbyte_reg <= rbyte_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = {24'h000000, rbyte_reg};
  assign s_axi_rresp = rresp_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_status_write;
    do_write && wr_mapped && w_lane_reg && (wr_idx == `OMD_IDX_STATUS);
  endsequence

  property p_soft_write;
    @(posedge ref_clk) disable iff (sys_rst)
      s_status_write |=> soft_dis_reg == $past(w_byte_reg[`OMD_ST_SOFT_DIS]) ##1
      tx_off_reg == (soft_dis_reg | $past(pin_stable_reg[0]));
  endproperty
  a_soft_write: assert property (p_soft_write) else $error("soft disable write lost");

  property p_tx_off;
    @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> tx_off_reg == $past(soft_dis_reg | pin_stable_reg[0]);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter off mismatch");

  property p_legacy_noop;
    @(posedge ref_clk) disable iff (sys_rst)
      do_write && wr_mapped && (wr_idx == `OMD_IDX_LEGACY)
      |=> $stable(soft_dis_reg) && bresp_reg == `OMD_RESP_OKAY;
  endproperty
  a_legacy_noop: assert property (p_legacy_noop) else $error("legacy byte write acted");

  property p_user_store;
    @(posedge ref_clk) disable iff (sys_rst)
      user_we |=> user_mem[7'($past(wr_idx) - `OMD_IDX_USER_FIRST)] == $past(w_byte_reg);
  endproperty
  a_user_store: assert property (p_user_store) else $error("user byte not stored");

  property p_full_bw;
    @(posedge ref_clk) disable iff (sys_rst) !$past(sys_rst) |-> full_bw_reg;
  endproperty
  a_full_bw: assert property (p_full_bw) else $error("bandwidth not full");

  property p_ready_bit;
    @(posedge ref_clk) disable iff (sys_rst)
      meas_valid |=> !status_byte[`OMD_ST_READY_N] [*3];
  endproperty
  a_ready_bit: assert property (p_ready_bit) else $error("ready bit not low");

  property p_los_read;
    @(posedge ref_clk) disable iff (sys_rst)
      s_axi_arvalid && arready_reg && (s_axi_araddr == ADDR_W'({`OMD_IDX_STATUS, 2'b00}))
      |=> s_axi_rvalid && s_axi_rdata[1] == $past(los_reg) && s_axi_rdata[5] == 1'b0;
  endproperty
  a_los_read: assert property (p_los_read) else $error("status read wrong");

  localparam int RX_LO = int'(OMD_CH_RXPWR) * `OMD_THR_STRIDE + `OMD_THR_LO_ALM;

  property p_rx_low;
    @(posedge ref_clk) disable iff (sys_rst)
      ready_reg && (meas_reg[OMD_CH_RXPWR] < {fact_mem[RX_LO], fact_mem[RX_LO+1]})
      |=> alm_rx_reg[6];
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("low alarm missed");

  property p_fault_mirror;
    @(posedge ref_clk) disable iff (sys_rst)
      tx_fault_in |=> tx_fault_pin && status_byte[`OMD_ST_FAULT];
  endproperty
  a_fault_mirror: assert property (p_fault_mirror) else $error("fault not mirrored");
endmodule

/* File: core/omdiag_params.svh */
`ifndef OMDIAG_PARAMS_SVH
`define OMDIAG_PARAMS_SVH

// ****************************************
// Byte indices within the page (byte address is four times the index)
// ****************************************
`define OMD_IDX_W 8
`define OMD_IDX_CHECKSUM 8'h5F
`define OMD_IDX_MEAS_FIRST 8'h60
`define OMD_IDX_MEAS_LAST 8'h69
`define OMD_IDX_STATUS 8'h6E
`define OMD_IDX_ALM_MAIN 8'h70
`define OMD_IDX_ALM_RX 8'h71
`define OMD_IDX_WRN_MAIN 8'h74
`define OMD_IDX_WRN_RX 8'h75
`define OMD_IDX_LEGACY 8'h7F
`define OMD_IDX_USER_FIRST 8'h80
`define OMD_IDX_USER_LAST 8'hF7
`define OMD_FACT_DEPTH 96
`define OMD_USER_DEPTH 120

// ****************************************
// Threshold layout inside the factory image
// ****************************************
`define OMD_THR_STRIDE 8
`define OMD_THR_HI_ALM 0
`define OMD_THR_LO_ALM 2
`define OMD_THR_HI_WRN 4
`define OMD_THR_LO_WRN 6

// ****************************************
// Status byte bit positions
// ****************************************
`define OMD_ST_TXDIS_PIN 7
`define OMD_ST_SOFT_DIS 6
`define OMD_ST_RATE_PIN 4
`define OMD_ST_FAULT 2
`define OMD_ST_LOS 1
`define OMD_ST_READY_N 0

// ****************************************
// Bus answers
// ****************************************
`define OMD_RESP_OKAY 2'h0
`define OMD_RESP_SLVERR 2'h2

`endif

/* File: core/omdiag_pkg.sv */
package omdiag_pkg;
  typedef enum logic [2:0] {
    OMD_CH_TEMP,
    OMD_CH_VCC,
    OMD_CH_BIAS,
    OMD_CH_TXPWR,
    OMD_CH_RXPWR
  } omd_channel_t;

  typedef enum logic {
    OMD_WR_COLLECT,
    OMD_WR_RESPOND
  } omd_wr_state_t;
endpackage

/* File: core/omdiag_flag_cmp.sv */
`timescale 1ns/1ps
module omdiag_flag_cmp #(
  parameter bit IS_SIGNED = 1'b0
) (
  input wire logic [15:0] value,
  input wire logic [15:0] hi_thr,
  input wire logic [15:0] lo_thr,
  output logic above_hi,
  output logic below_lo
);
  always_comb begin
    if (IS_SIGNED) begin
      above_hi = $signed(value) > $signed(hi_thr);
      below_lo = $signed(value) < $signed(lo_thr);
    end else begin
      above_hi = value > hi_thr;
      below_lo = value < lo_thr;
    end
  end
endmodule

/* File: dv/omdiag_host.sv */
`timescale 1ns/1ps
// ****************************************
// AXI4-Lite master standing in for the host controller
// ****************************************
module omdiag_host (
  input wire logic ref_clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
    {araddr, arvalid, rready} <= '0;
  end

  // Released payload is inverted so stale values cannot pass for live ones
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic s,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= {3'h0, s};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~{24'h000000, d};
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

/* File: dv/tb_optical_module_diag_status_bank.sv */
`timescale 1ns/1ps
`include "omdiag_params.svh"
module tb_optical_module_diag_status_bank;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic factory_we = 1'b0;
  logic [6:0] factory_idx = 7'h00;
  logic [7:0] factory_byte = 8'h00;
  logic [15:0] meas [5] = '{default: 16'h0000};
  logic meas_valid = 1'b0;
  logic tx_fault_in = 1'b0;
  logic signal_loss_in = 1'b0;
  logic tx_disable_pin = 1'b0;
  logic rate_select_pin = 1'b0;
  logic tx_fault_pin, signal_loss_pin_level, transmitter_off, full_bandwidth;
  int err_total = 0;
  int comparisons = 0;
  logic [15:0] thr [5][4];
  logic [7:0] image [96];
  localparam logic [15:0] MV [5] = '{16'hFF80, 16'h9000, 16'h1800, 16'h7000, 16'h0800};

  always #5 ref_clk = ~ref_clk;

  omdiag_bank dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .factory_we(factory_we), .factory_idx(factory_idx), .factory_byte(factory_byte),
    .temp_meas(meas[0]), .vcc_meas(meas[1]), .bias_meas(meas[2]), .txpwr_meas(meas[3]),
    .rxpwr_meas(meas[4]), .meas_valid(meas_valid), .tx_fault_in(tx_fault_in),
    .signal_loss_in(signal_loss_in), .tx_disable_pin(tx_disable_pin),
    .rate_select_pin(rate_select_pin), .tx_fault_pin(tx_fault_pin),
    .signal_loss_pin_level(signal_loss_pin_level), .transmitter_off(transmitter_off),
    .full_bandwidth(full_bandwidth));

  omdiag_host host (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(ba(idx), d, r);
    chk($sformatf("byte %0d", idx), {24'h000000, exp}, d);
    chk("rresp", {30'h0, `OMD_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic wrchk(input logic [11:0] a, input logic [7:0] d, input logic s,
                       input logic [1:0] exp);
    logic [1:0] r;
    host.wr(a, d, s, r);
    chk("bresp", {30'h0, exp}, {30'h0, r});
  endtask

  task automatic finish_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("full_bandwidth", 32'h1, {31'h0, full_bandwidth});
    chk("transmitter_off", 32'h0, {31'h0, transmitter_off});
    rdchk(`OMD_IDX_STATUS, 8'h01);
    rdchk(`OMD_IDX_ALM_MAIN, 8'h00);
  endtask

  task automatic t_factory();
    for (int k = 0; k < 5; k++) begin
      if (k == 0) begin
        thr[k] = '{16'h5000, 16'h0000, 16'h4000, 16'h0800};
      end else begin
        thr[k] = '{16'h8000, 16'h1000, 16'h6000, 16'h2000};
      end
      for (int j = 0; j < 4; j++) begin
        image[8 * k + 2 * j] = thr[k][j][15:8];
        image[8 * k + 2 * j + 1] = thr[k][j][7:0];
      end
    end
    for (int i = 40; i < 95; i++) begin
      image[i] = 8'h5A ^ 8'(i);
    end
    image[95] = 8'hC3;
    for (int i = 0; i < 96; i++) begin
      @(posedge ref_clk);
      factory_we <= 1'b1;
      factory_idx <= 7'(i);
      factory_byte <= image[i];
    end
    @(posedge ref_clk);
    factory_we <= 1'b0;
    wrchk(ba(`OMD_IDX_CHECKSUM), 8'h00, 1'b1, `OMD_RESP_OKAY);
    wrchk(ba(8'd60), 8'h00, 1'b1, `OMD_RESP_OKAY);
    rdchk(`OMD_IDX_CHECKSUM, 8'hC3);
    rdchk(8'd60, image[60]);
    rdchk(8'd0, 8'h50);
  endtask

  task automatic t_meas();
    @(posedge ref_clk);
    for (int k = 0; k < 5; k++) begin
      meas[k] <= MV[k];
    end
    meas_valid <= 1'b1;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 5; k++) begin
      rdchk(8'(96 + 2 * k), MV[k][15:8]);
      rdchk(8'(97 + 2 * k), MV[k][7:0]);
    end
    // Signed temp below zero is low; vcc over both highs; bias under low warning only;
    // tx power over high warning only; rx power under both lows
    rdchk(`OMD_IDX_ALM_MAIN, 8'h60);
    rdchk(`OMD_IDX_ALM_RX, 8'h40);
    rdchk(`OMD_IDX_WRN_MAIN, 8'h66);
    rdchk(`OMD_IDX_WRN_RX, 8'h40);
  endtask

  task automatic t_pins();
    @(posedge ref_clk);
    {tx_disable_pin, rate_select_pin, tx_fault_in, signal_loss_in} <= 4'hF;
    repeat (8) @(posedge ref_clk);
    chk("transmitter_off", 32'h1, {31'h0, transmitter_off});
    chk("full_bandwidth", 32'h1, {31'h0, full_bandwidth});
    chk("tx_fault_pin", 32'h1, {31'h0, tx_fault_pin});
    chk("signal_loss", 32'h1, {31'h0, signal_loss_pin_level});
    rdchk(`OMD_IDX_STATUS, 8'h96);
    @(posedge ref_clk);
    {tx_disable_pin, rate_select_pin, tx_fault_in, signal_loss_in} <= 4'h0;
    wrchk(ba(`OMD_IDX_STATUS), 8'hFF, 1'b1, `OMD_RESP_OKAY);
    repeat (8) @(posedge ref_clk);
    rdchk(`OMD_IDX_STATUS, 8'h40);
    chk("transmitter_off", 32'h1, {31'h0, transmitter_off});
    wrchk(ba(`OMD_IDX_STATUS), 8'h00, 1'b1, `OMD_RESP_OKAY);
    repeat (4) @(posedge ref_clk);
    chk("transmitter_off", 32'h0, {31'h0, transmitter_off});
  endtask

  task automatic t_space();
    logic [31:0] d;
    logic [1:0] r;
    wrchk(ba(`OMD_IDX_LEGACY), 8'hA5, 1'b1, `OMD_RESP_OKAY);
    rdchk(`OMD_IDX_LEGACY, 8'h00);
    rdchk(`OMD_IDX_STATUS, 8'h00);
    wrchk(ba(`OMD_IDX_USER_FIRST), 8'h3C, 1'b1, `OMD_RESP_OKAY);
    wrchk(ba(`OMD_IDX_USER_LAST), 8'hC5, 1'b1, `OMD_RESP_OKAY);
    wrchk(ba(8'h81), 8'hFF, 1'b0, `OMD_RESP_OKAY);
    rdchk(`OMD_IDX_USER_FIRST, 8'h3C);
    rdchk(`OMD_IDX_USER_LAST, 8'hC5);
    rdchk(8'h81, 8'h00);
    wrchk(12'h400, 8'h11, 1'b1, `OMD_RESP_SLVERR);
    host.rd(12'h400, d, r);
    chk("unmapped rdata", 32'h0, d);
    chk("unmapped rresp", {30'h0, `OMD_RESP_SLVERR}, {30'h0, r});
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_reset();
    t_factory();
    t_meas();
    t_pins();
    t_space();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end
endmodule
